// ### verilog/ecc_pkg.sv
// Package: constants and carriers for the child-count increment leaf unit
package ecc_pkg;
  localparam int ADDR_W = 64;
  localparam logic [31:0] LEAF_CHILD_INC = 32'h0000_0001;
  localparam logic [31:0] LEAF_CTX_SET = 32'h0000_0002;
  localparam int FEATURE_BIT = 5;
  localparam logic [1:0] PRIV_LEVEL_REQ = 2'h0;
  localparam int PAGE_ALIGN_BITS = 12;
  localparam logic [7:0] PAGE_CONFLICT_CODE = 8'h09;
  localparam logic [63:0] RESULT_OK = 64'h0;
  localparam int CNT_W = 64;
  // Register map (byte offsets, compared directly against the Avalon address)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_FAULT = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_CTX = 8'h18;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam logic [31:0] UNMAPPED_READ = 32'h0;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_GEN_PROT = 2'h1;
  localparam logic [1:0] FAULT_PAGE = 2'h2;
  localparam logic [1:0] FAULT_UD = 2'h3;

  typedef enum logic [2:0] {
    PT_REGULAR, PT_THREAD_CTRL, PT_TRIMMED, PT_SHADOW_FIRST, PT_SHADOW_LATER, PT_CTRL_STRUCT,
    PT_OTHER
  } ecc_page_type_t;

  // Request issued by the core pipeline
  typedef struct packed {
    logic [31:0] leaf;
    logic [63:0] target_ea;
    logic [63:0] struct_ea;
    logic [63:0] ctx_ea;
    logic [1:0] priv;
    logic long_mode;
    logic seg_usable;
    logic [31:0] seg_limit;
    logic seg_override;
    logic [31:0] feature_eax;
  } ecc_req_t;

  // Page environment seen from the memory subsystem
  typedef struct packed {
    logic target_in_prot;
    logic struct_in_prot;
    logic target_busy;
    logic target_valid;
    ecc_page_type_t target_type;
    logic [63:0] target_pa;
    logic [63:0] target_owner_pa;
    logic [63:0] struct_pa;
    logic xlate_fault;
  } ecc_env_t;

  typedef struct packed {
    logic [1:0] fault;
    logic prot_fault_ind;
    logic fault_on_struct;
    logic zero_flag;
    logic carry_flag;
    logic parity_flag;
    logic auxiliary_carry_flag;
    logic overflow_flag;
    logic sign_flag;
    logic [63:0] result;
  } ecc_resp_t;
endpackage

// ### verilog/ecc_check.sv
// Ordered legality checks for one leaf request
module ecc_check (
  input wire ecc_pkg::ecc_req_t req_i,
  input wire ecc_pkg::ecc_env_t env_i,
  output logic [1:0] fault_o,
  output logic prot_ind_o,
  output logic on_struct_o,
  output logic conflict_o,
  output logic pass_o
);
  import ecc_pkg::*;

  function automatic logic canon_ok(input logic [63:0] a);
    canon_ok = (a[63:47] == {17{1'b0}}) || (a[63:47] == {17{1'b1}});
  endfunction

  function automatic logic lim_ok(input logic [63:0] a, input logic [31:0] lim);
    lim_ok = (a[63:32] == 32'h0) && (a[31:0] <= lim);
  endfunction

  logic [63:0] derived_structure_address;
  logic type_ok;

  always_comb begin
    fault_o = FAULT_NONE;
    prot_ind_o = 1'b0;
    on_struct_o = 1'b0;
    conflict_o = 1'b0;
    pass_o = 1'b0;
    type_ok = 1'b1;
    derived_structure_address = env_i.target_pa;
    case (env_i.target_type)
      PT_REGULAR, PT_THREAD_CTRL, PT_TRIMMED, PT_SHADOW_FIRST, PT_SHADOW_LATER: begin
        derived_structure_address = env_i.target_owner_pa;
      end
      PT_CTRL_STRUCT: begin
        derived_structure_address = env_i.target_pa;
      end
      default: begin
        type_ok = 1'b0;
      end
    endcase
    // First failing check wins
    if (!req_i.feature_eax[FEATURE_BIT] || req_i.priv != PRIV_LEVEL_REQ
        || req_i.seg_override) begin
      fault_o = (req_i.priv != PRIV_LEVEL_REQ) ? FAULT_GEN_PROT : FAULT_UD;
    end else if (!req_i.long_mode && (!req_i.seg_usable
        || !lim_ok(req_i.target_ea, req_i.seg_limit)
        || !lim_ok(req_i.struct_ea, req_i.seg_limit))) begin
      fault_o = FAULT_GEN_PROT;
    end else if (req_i.long_mode && (!canon_ok(req_i.target_ea)
        || !canon_ok(req_i.struct_ea))) begin
      fault_o = FAULT_GEN_PROT;
    end else if (req_i.target_ea[PAGE_ALIGN_BITS-1:0] != '0) begin
      fault_o = FAULT_GEN_PROT;
    end else if (!env_i.target_in_prot) begin
      fault_o = FAULT_PAGE;
      prot_ind_o = 1'b1;
    end else if (!env_i.struct_in_prot) begin
      fault_o = FAULT_PAGE;
      prot_ind_o = 1'b1;
      on_struct_o = 1'b1;
    end else if (env_i.xlate_fault) begin
      fault_o = FAULT_PAGE;
    end else if (env_i.target_busy) begin
      conflict_o = 1'b1;
    end else if (!env_i.target_valid) begin
      fault_o = FAULT_PAGE;
      prot_ind_o = 1'b1;
    end else if (!type_ok) begin
      fault_o = FAULT_PAGE;
      prot_ind_o = 1'b1;
    end else if (derived_structure_address != env_i.struct_pa) begin
      fault_o = FAULT_GEN_PROT;
    end else begin
      pass_o = 1'b1;
    end
  end
endmodule

// ### verilog/ecc_counter.sv
// Virtual-child counter storage with atomic increment and context field
module ecc_counter #(
  parameter int CNT_WIDTH = 64
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic inc_i,
  input wire logic ctx_we_i,
  input wire logic [63:0] ctx_i,
  output logic [CNT_WIDTH-1:0] count_o,
  output logic [63:0] ctx_o
);
  import ecc_pkg::*;
  logic [CNT_WIDTH-1:0] cnt_reg, cnt_next;
  logic [63:0] ctx_reg, ctx_next;

  always_comb begin
    cnt_next = cnt_reg;
    ctx_next = ctx_reg;
    // Single-cycle update keeps the increment atomic
    if (inc_i) begin
      cnt_next = cnt_reg + CNT_WIDTH'(1);
    end
    if (ctx_we_i) begin
      ctx_next = ctx_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      ctx_reg <= '0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      ctx_reg <= ctx_next;
    end
  end

  assign count_o = cnt_reg;
  assign ctx_o = ctx_reg;
endmodule

// ### verilog/ecc_top.sv
// Execution unit for the virtualization leaf group: child-count increment
//////////////////////////////////////////////////////////////////////////////
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
module ecc_top #(
  parameter int CNT_WIDTH = ecc_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire ecc_pkg::ecc_req_t req_i,
  input wire ecc_pkg::ecc_env_t env_i,
  input wire logic [63:0] ctx_value_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output ecc_pkg::ecc_resp_t resp_o,
  output logic done_o,
  output logic target_wr_ok_o,
  output logic struct_wr_ok_o
);
  import ecc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_EXEC, ST_DONE} ecc_state_t;

  ecc_state_t state_reg, state_next;
  ecc_resp_t resp_reg, resp_next;
  logic done_reg, done_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic start_pend_reg, start_pend_next;
  logic [1:0] fault_w;
  logic prot_ind_w, on_struct_w, conflict_w, pass_w;
  logic inc_w, ctx_we_w;
  logic [CNT_WIDTH-1:0] count_w;
  logic [63:0] ctx_w;
  logic is_inc, is_ctx;

  ecc_check u_check (
    .req_i(req_i),
    .env_i(env_i),
    .fault_o(fault_w),
    .prot_ind_o(prot_ind_w),
    .on_struct_o(on_struct_w),
    .conflict_o(conflict_w),
    .pass_o(pass_w)
  );

  ecc_counter #(.CNT_WIDTH(CNT_WIDTH)) u_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .inc_i(inc_w),
    .ctx_we_i(ctx_we_w),
    .ctx_i(ctx_value_i),
    .count_o(count_w),
    .ctx_o(ctx_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Leaf decode
  assign is_inc = (req_i.leaf == LEAF_CHILD_INC);
  assign is_ctx = (req_i.leaf == LEAF_CTX_SET);
  // Structure operand is only ever read; target may be written
  assign target_wr_ok_o = (state_reg == ST_EXEC) && is_inc;
  assign struct_wr_ok_o = 1'b0;
  // Concurrency only against the target page busy signal
  assign inc_w = (state_reg == ST_EXEC) && is_inc && pass_w && ce_i;
  // Context leaf reuses checks; its own detailed checks live elsewhere
  assign ctx_we_w = (state_reg == ST_EXEC) && is_ctx && (fault_w == FAULT_NONE)
                    && !conflict_w && ce_i;

  //////////////////////////////////////////////////////////////////////////////
  // Execution sequence
  always_comb begin
    state_next = state_reg;
    resp_next = resp_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_pend_reg) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        resp_next = '0;
        if (!(is_inc || is_ctx)) begin
          resp_next.fault = FAULT_UD;
        end else begin
          resp_next.fault = fault_w;
          resp_next.prot_fault_ind = prot_ind_w;
          resp_next.fault_on_struct = on_struct_w;
          if (conflict_w) begin
            resp_next.zero_flag = 1'b1;
            resp_next.result = {56'h0, PAGE_CONFLICT_CODE};
          end else if (fault_w == FAULT_NONE) begin
            resp_next.zero_flag = 1'b0;
            resp_next.result = RESULT_OK;
          end
        end
        // Arithmetic flags cleared on every path
        resp_next.carry_flag = 1'b0;
        resp_next.parity_flag = 1'b0;
        resp_next.auxiliary_carry_flag = 1'b0;
        resp_next.overflow_flag = 1'b0;
        resp_next.sign_flag = 1'b0;
        done_next = 1'b1;
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      resp_reg <= '0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      resp_reg <= resp_next;
      done_reg <= done_next;
    end
  end

  assign resp_o = resp_reg;
  assign done_o = done_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state on every access while ce_i is high (waitrequest holds while ce_i is low), then answer
  function automatic logic [31:0] apply_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    apply_be = r;
  endfunction

  always_comb begin
    ctrl_next = ctrl_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    start_pend_next = start_pend_reg;
    // Start is a self-clearing command; the latch holds it until the FSM takes it
    if (state_reg == ST_IDLE && start_pend_reg) begin
      start_pend_next = 1'b0;
    end
    // Write lands only at the edge where the master sees waitrequest low
    if (avs_write_i && ack_reg && avs_address_i == OFS_CTRL) begin
      ctrl_next = apply_be(ctrl_reg, avs_writedata_i, avs_byteenable_i);
      if (avs_byteenable_i[0] && avs_writedata_i[CTRL_START_BIT]) begin
        start_pend_next = 1'b1;
      end
      ctrl_next[CTRL_START_BIT] = 1'b0;
    end
    if ((avs_read_i || avs_write_i) && !ack_reg) begin
      ack_next = 1'b1;
      if (avs_read_i) begin
        case (avs_address_i)
          OFS_CTRL: rdata_next = ctrl_reg;
          OFS_STATUS: rdata_next = {30'h0, state_reg == ST_DONE || done_reg,
                                    state_reg != ST_IDLE};
          OFS_RESULT: rdata_next = resp_reg.result[31:0];
          OFS_FLAGS: rdata_next = {26'h0, resp_reg.sign_flag, resp_reg.overflow_flag,
                                   resp_reg.auxiliary_carry_flag, resp_reg.parity_flag,
                                   resp_reg.carry_flag, resp_reg.zero_flag};
          OFS_FAULT: rdata_next = {28'h0, resp_reg.fault_on_struct, resp_reg.prot_fault_ind,
                                   resp_reg.fault};
          OFS_COUNT: rdata_next = count_w[31:0];
          OFS_CTX: rdata_next = ctx_w[31:0];
          default: rdata_next = UNMAPPED_READ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET;
      rdata_reg <= '0;
      ack_reg <= 1'b0;
      start_pend_reg <= 1'b0;
    end else if (ce_i) begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      start_pend_reg <= start_pend_next;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
  assign avs_readdata_o = rdata_reg;
endmodule

// ### tb/ecc_top_sva.sv
// Checker: port-level properties of the child-count increment unit
module ecc_top_sva
  import ecc_pkg::*;
#(
  parameter int CNT_WIDTH = 64
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire ecc_pkg::ecc_req_t req_i,
  input wire ecc_pkg::ecc_env_t env_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire ecc_pkg::ecc_resp_t resp_o,
  input wire logic done_o,
  input wire logic target_wr_ok_o,
  input wire logic struct_wr_ok_o
);
  logic inc_lf;
  // Only a decodable increment request is judged; other leaves have their own rules
  assign inc_lf = req_i.leaf == LEAF_CHILD_INC && req_i.feature_eax[FEATURE_BIT]
    && !req_i.seg_override;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  done_pulse_a: assert property (done_o && ce_i |=> !done_o)
    else $error("done held longer than one cycle");
  flags_clear_a: assert property (done_o && inc_lf |->
    !(resp_o.carry_flag || resp_o.parity_flag || resp_o.auxiliary_carry_flag
    || resp_o.overflow_flag || resp_o.sign_flag))
    else $error("arithmetic flags not cleared");
  zero_conflict_a: assert property (done_o && resp_o.zero_flag |->
    resp_o.fault == FAULT_NONE && resp_o.result == 64'(PAGE_CONFLICT_CODE))
    else $error("zero flag without conflict code");
  zero_only_busy_a: assert property (done_o && inc_lf && !env_i.target_busy
    |-> !resp_o.zero_flag) else $error("zero flag set without busy page");
  ok_result_a: assert property (done_o && inc_lf && resp_o.fault == FAULT_NONE
    && !resp_o.zero_flag |-> resp_o.result == RESULT_OK) else $error("success result not zero");
  priv_refuse_a: assert property (done_o && inc_lf && req_i.priv != PRIV_LEVEL_REQ
    |-> resp_o.fault == FAULT_GEN_PROT) else $error("wrong privilege not refused");
  align_refuse_a: assert property (done_o && inc_lf && req_i.target_ea[11:0] != 12'h0
    |-> resp_o.fault == FAULT_GEN_PROT) else $error("misaligned target not refused");
  exec_done_a: assert property (target_wr_ok_o && ce_i |=> done_o)
    else $error("exec cycle not followed by done");
  struct_ro_a: assert property (!struct_wr_ok_o)
    else $error("structure operand opened for write");
  bus_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus wait state longer than one cycle");
endmodule

bind ecc_top ecc_top_sva #(.CNT_WIDTH(CNT_WIDTH)) chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .ce_i(ce_i), .req_i(req_i), .env_i(env_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .resp_o(resp_o),
  .done_o(done_o), .target_wr_ok_o(target_wr_ok_o), .struct_wr_ok_o(struct_wr_ok_o));

// ### tb/tb.sv
// Testbench: drives the increment unit through its request and bus ports
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ecc_pkg::*;
  `define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  ecc_req_t req_i;
  ecc_env_t env_i;
  logic [63:0] ctx_value_i = 64'h0123_4567_89ab_cdef;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  ecc_resp_t resp_o;
  logic done_o;
  logic target_wr_ok_o;
  logic struct_wr_ok_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] cnt_exp = 32'h0;
  logic [31:0] rdata;

  always #2 clk_i = ~clk_i;

  ecc_top #(.CNT_WIDTH(64)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .req_i(req_i), .env_i(env_i), .ctx_value_i(ctx_value_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .resp_o(resp_o), .done_o(done_o),
    .target_wr_ok_o(target_wr_ok_o), .struct_wr_ok_o(struct_wr_ok_o));
  //////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    do begin @(posedge clk_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin n_mismatch++; end_of_test(); end
  endtask

  function automatic ecc_req_t good_req();
    ecc_req_t r;
    r = '0;
    r.leaf = LEAF_CHILD_INC;
    r.target_ea = 64'h1000;
    r.struct_ea = 64'h2000;
    r.ctx_ea = 64'h3000;
    r.long_mode = 1'b1;
    r.seg_usable = 1'b1;
    r.seg_limit = 32'hffff_ffff;
    r.feature_eax[FEATURE_BIT] = 1'b1;
    return r;
  endfunction

  function automatic ecc_env_t good_env();
    ecc_env_t e;
    e = '0;
    e.target_in_prot = 1'b1;
    e.struct_in_prot = 1'b1;
    e.target_valid = 1'b1;
    e.target_type = PT_REGULAR;
    e.target_pa = 64'h8000;
    e.target_owner_pa = 64'h9000;
    e.struct_pa = 64'h9000;
    return e;
  endfunction

  // Request stays steady from start until done, as the unit requires
  task run(input ecc_req_t r, input ecc_env_t e, input logic [1:0] f, input logic z);
    int n;
    logic [4:0] arith;
    n = 0;
    @(posedge clk_i);
    req_i <= r;
    env_i <= e;
    bus(1'b1, OFS_CTRL, 32'h1);
    do begin @(posedge clk_i); n++; end while (done_o !== 1'b1 && n < 50);
    if (done_o !== 1'b1) begin n_mismatch++; end_of_test(); end
    `CHK("fault", f, resp_o.fault)
    `CHK("zero flag", z, resp_o.zero_flag)
    arith = {resp_o.carry_flag, resp_o.parity_flag, resp_o.auxiliary_carry_flag,
             resp_o.overflow_flag, resp_o.sign_flag};
    `CHK("arith flags", 5'h0, arith)
    if (z) `CHK("result", 64'(PAGE_CONFLICT_CODE), resp_o.result)
    if (f == FAULT_NONE && !z) `CHK("result", RESULT_OK, resp_o.result)
    if (f == FAULT_NONE && !z && r.leaf == LEAF_CHILD_INC) cnt_exp = cnt_exp + 32'h1;
    bus(1'b0, OFS_COUNT, 32'h0);
    `CHK("count", cnt_exp, rdata)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task s_regs;
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", UNMAPPED_READ, rdata)
    bus(1'b1, OFS_COUNT, 32'h55);
    bus(1'b0, OFS_COUNT, 32'h0);
    `CHK("count ro", 32'h0, rdata)
  endtask

  // Control page must use its own address, so its owner field is made wrong
  task s_types;
    ecc_req_t r;
    ecc_env_t e;
    for (int t = 0; t < 6; t++) begin
      r = good_req();
      e = good_env();
      e.target_type = ecc_page_type_t'(t);
      if (e.target_type == PT_CTRL_STRUCT) begin
        e.target_pa = 64'h9000;
        e.target_owner_pa = 64'h7000;
      end
      run(r, e, FAULT_NONE, 1'b0);
    end
  endtask

  // Busy page wins over a later invalid page and wrong type
  task s_conflict;
    ecc_env_t e;
    e = good_env();
    e.target_busy = 1'b1;
    e.target_valid = 1'b0;
    e.target_type = PT_OTHER;
    run(good_req(), e, FAULT_NONE, 1'b1);
    bus(1'b0, OFS_FLAGS, 32'h0);
    `CHK("flag reg", 32'h1, rdata)
    bus(1'b0, OFS_RESULT, 32'h0);
    `CHK("result reg", {24'h0, PAGE_CONFLICT_CODE}, rdata)
  endtask

  task s_faults;
    ecc_req_t r;
    ecc_env_t e;
    logic [1:0] ex [16];
    ex = '{FAULT_GEN_PROT, FAULT_GEN_PROT, FAULT_PAGE, FAULT_PAGE, FAULT_PAGE, FAULT_PAGE,
      FAULT_GEN_PROT, FAULT_GEN_PROT, FAULT_UD, FAULT_UD, FAULT_GEN_PROT, FAULT_GEN_PROT,
      FAULT_GEN_PROT, FAULT_PAGE, FAULT_UD, FAULT_GEN_PROT};
    for (int i = 0; i < 16; i++) begin
      r = good_req();
      e = good_env();
      case (i)
        0: r.target_ea = 64'h1800;
        1: begin r.target_ea = 64'h1800; e.target_in_prot = 1'b0; end
        2: e.target_in_prot = 1'b0;
        3: e.struct_in_prot = 1'b0;
        4: e.target_valid = 1'b0;
        5: e.target_type = PT_OTHER;
        6: e.target_owner_pa = 64'h9040;
        7: r.priv = 2'h3;
        8: r.feature_eax = 32'h0;
        9: r.seg_override = 1'b1;
        10: r.target_ea = 64'h0000_8000_0000_1000;
        11: begin r.long_mode = 1'b0; r.seg_usable = 1'b0; end
        12: begin r.long_mode = 1'b0; r.seg_limit = 32'h1fff; end
        13: e.xlate_fault = 1'b1;
        14: r.leaf = 32'h3;
        default: begin r.target_ea = 64'h1800; e.target_busy = 1'b1; end
      endcase
      run(r, e, ex[i], 1'b0);
      if (i == 2 || i == 3) begin
        `CHK("prot ind", 1'b1, resp_o.prot_fault_ind)
        `CHK("on struct", (i == 3), resp_o.fault_on_struct)
      end
      if (i == 3) begin
        bus(1'b0, OFS_FAULT, 32'h0);
        `CHK("fault reg", {28'h0, 2'b11, FAULT_PAGE}, rdata)
      end
    end
  endtask

  task s_ctx;
    ecc_req_t r;
    ecc_env_t e;
    r = good_req();
    e = good_env();
    r.leaf = LEAF_CTX_SET;
    r.target_ea = r.struct_ea;
    e.target_type = PT_CTRL_STRUCT;
    e.target_pa = 64'h9000;
    run(r, e, FAULT_NONE, 1'b0);
    bus(1'b0, OFS_CTX, 32'h0);
    `CHK("context", ctx_value_i[31:0], rdata)
  endtask

  // Clock enable low must hold a pending start; it runs once enable returns
  task s_freeze;
    int n;
    n = 0;
    req_i <= good_req();
    env_i <= good_env();
    bus(1'b1, OFS_CTRL, 32'h1);
    ce_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("frozen done", 1'b0, done_o)
    `CHK("frozen exec", 1'b0, target_wr_ok_o)
    ce_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (done_o !== 1'b1 && n < 50);
    if (done_o !== 1'b1) begin n_mismatch++; end_of_test(); end
    cnt_exp = cnt_exp + 32'h1;
    bus(1'b0, OFS_COUNT, 32'h0);
    `CHK("count", cnt_exp, rdata)
  endtask

  initial begin
    req_i = good_req();
    env_i = good_env();
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    s_regs();
    s_types();
    s_conflict();
    s_faults();
    s_ctx();
    s_freeze();
    end_of_test();
  end
endmodule
